// [src/reset_sequencer.sv]
/*
  Reset sequencer top: machine-cycle counters, reset sampling and procedure,
  port latch defaults, address latch strobe timing and oscillator watchdog.
  Assumes clk is one oscillator period and pin inputs are asynchronous.
*/
module reset_sequencer
  import reset_seq_pkg::*;
#(
  parameter logic [9:0] HOLD_LAST = WDOG_HOLD_LAST
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic reset_pin,
  input wire logic rc_tick_pin,
  input wire logic main_edge_pin,
  input wire logic ext_fetch,
  input wire logic external_data_move,
  input wire logic data_strobe_active,
  input wire logic power_down_req,
  input wire logic ale_in,
  input wire logic program_read_strobe_in,
  output logic ale_out,
  output logic ale_oe_n,
  output logic program_read_strobe_out,
  output logic program_read_strobe_oe_n,
  output logic [7:0] port0_latch,
  output logic [7:0] port1_latch,
  output logic [7:0] port2_latch,
  output logic [7:0] port3_latch,
  output logic [15:0] pc_start,
  output logic cpu_reset,
  output logic cpu_run,
  output logic sfr_default_load,
  output logic addr_out_start,
  output logic use_rc_clock,
  output logic osc_failure_flag,
  output logic power_down,
  output logic test_mode_hazard
);
  import reset_seq_pkg::*;

  seq_state_t state_q;
  seq_state_t state_d;
  logic [1:0] reset_sync_q;
  logic [1:0] rc_sync_q;
  logic [1:0] main_sync_q;
  logic [1:0] ale_sync_q;
  logic [1:0] prs_sync_q;
  logic main_prev_q;
  logic rc_prev_q;
  logic [2:0] st_q;
  logic ph_q;
  logic reset_seen_q;
  logic [1:0] init_cnt_q;
  logic osc_failure_flag_q;
  logic pd_q;
  logic ale_q;
  logic prs_q;
  logic move_second_q;
  logic [7:0] port_q [PORT_COUNT];
  logic rc_tick;
  logic main_edge;
  logic wdog_req;
  logic wdog_fail;
  logic sample_pt;
  logic cycle_end;
  logic reset_level;
  logic in_reset;
  logic ale_slot;
  logic run_next;
  logic ale_suppress;

  ////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers; edge detectors read the second flop only
  always_ff @(posedge clk) begin
    if (srst) begin
      reset_sync_q <= 2'h0;
      rc_sync_q <= 2'h0;
      main_sync_q <= 2'h0;
      ale_sync_q <= 2'h0;
      prs_sync_q <= 2'h0;
      rc_prev_q <= 1'b0;
      main_prev_q <= 1'b0;
    end else begin
      reset_sync_q <= {reset_sync_q[0], reset_pin};
      rc_sync_q <= {rc_sync_q[0], rc_tick_pin};
      main_sync_q <= {main_sync_q[0], main_edge_pin};
      ale_sync_q <= {ale_sync_q[0], ale_in};
      prs_sync_q <= {prs_sync_q[0], program_read_strobe_in};
      rc_prev_q <= rc_sync_q[1];
      main_prev_q <= main_sync_q[1];
    end
  end

  assign rc_tick = rc_sync_q[1] && !rc_prev_q;
  assign main_edge = main_sync_q[1] && !main_prev_q;
  assign reset_level = reset_sync_q[1];

  ////////////////////////////////////////////////////////////////////////
  // Oscillator watchdog
  osc_watchdog #(
    .HOLD_LAST(HOLD_LAST)
  ) u_wdog (
    .clk(clk),
    .srst(srst),
    .rc_tick(rc_tick),
    .main_edge(main_edge),
    .use_rc_clock(use_rc_clock),
    .wdog_reset_req(wdog_req),
    .fail_event(wdog_fail)
  );

  ////////////////////////////////////////////////////////////////////////
  // State and phase counters: six states of two phases
  assign cycle_end = (st_q == STATE_LAST) && (ph_q == PHASE_2);
  assign sample_pt = (st_q == STATE_S5) && (ph_q == PHASE_2);

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= 3'h0;
      ph_q <= PHASE_1;
    end else begin
      ph_q <= ~ph_q;
      if (ph_q == PHASE_2) begin
        st_q <= cycle_end ? 3'h0 : st_q + 3'h1;
      end
    end
  end

  // Reset sampled once per machine cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      reset_seen_q <= 1'b1;
    end else if (sample_pt) begin
      reset_seen_q <= reset_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer: reset, two-cycle procedure, wait for S5P1, run
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_RESET: begin
        if (cycle_end && !reset_seen_q && !wdog_req) begin
          state_d = ST_WAIT;
        end else if (cycle_end) begin
          state_d = ST_INIT;
        end
      end
      ST_INIT: begin
        // Procedure repeats each cycle while reset is still seen
        if (cycle_end && init_cnt_q == RESET_CYCLES - 2'h1 && !reset_seen_q && !wdog_req) begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (reset_seen_q || wdog_req) begin
          state_d = ST_RESET;
        end else if (st_q == STATE_S5 && ph_q == PHASE_1) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (reset_seen_q || wdog_req) begin
          state_d = ST_RESET;
        end
      end
      default: state_d = ST_RESET;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= ST_RESET;
      init_cnt_q <= 2'h0;
    end else begin
      state_q <= state_d;
      if (state_q != ST_INIT) begin
        init_cnt_q <= 2'h0;
      end else if (cycle_end && init_cnt_q != RESET_CYCLES - 2'h1) begin
        init_cnt_q <= init_cnt_q + 2'h1;
      end
    end
  end

  assign in_reset = (state_q == ST_RESET) || (state_q == ST_INIT) || (state_q == ST_WAIT);
  assign cpu_reset = in_reset;
  assign cpu_run = state_q == ST_RUN;
  assign sfr_default_load = state_q == ST_INIT;
  assign addr_out_start = (state_q == ST_WAIT) && (state_d == ST_RUN);
  assign pc_start = PC_RESET;

  ////////////////////////////////////////////////////////////////////////
  // Port latches forced to ones by the procedure; RAM is not touched here
  always_ff @(posedge clk) begin
    for (int i = 0; i < PORT_COUNT; i++) begin
      if (srst || sfr_default_load) begin
        port_q[i] <= PORT_RESET;
      end
    end
  end

  assign port0_latch = port_q[0];
  assign port1_latch = port_q[1];
  assign port2_latch = port_q[2];
  assign port3_latch = port_q[3];

  ////////////////////////////////////////////////////////////////////////
  // Failure flag and power-down: only external reset clears them
  always_ff @(posedge clk) begin
    if (srst) begin
      osc_failure_flag_q <= 1'b1;
      pd_q <= 1'b0;
    end else begin
      if (wdog_fail) begin
        osc_failure_flag_q <= 1'b1;
      end else if (reset_seen_q) begin
        osc_failure_flag_q <= 1'b0;
      end
      if (reset_seen_q) begin
        pd_q <= 1'b0;
      end else if (power_down_req && cpu_run) begin
        pd_q <= 1'b1;
      end
    end
  end

  assign osc_failure_flag = osc_failure_flag_q;
  assign power_down = pd_q;

  ////////////////////////////////////////////////////////////////////////
  // Address latch strobe: high S1P2-S2P1 and S4P2-S5P1, falls S2P2/S5P2
  // Registered strobe is set one clock early: next clock is S1P2, S2P1, S4P2 or S5P1
  assign ale_slot = (st_q == 3'h0) || (st_q == 3'h3);
  // First strobe of run comes at the S5P1 where address output starts
  assign run_next = cpu_run || ((state_q == ST_WAIT) && !reset_seen_q && !wdog_req &&
                    (st_q == 3'h3) && (ph_q == PHASE_2));
  assign ale_suppress = move_second_q && data_strobe_active && (st_q <= STATE_S2);

  always_ff @(posedge clk) begin
    if (srst) begin
      move_second_q <= 1'b0;
    end else if (cycle_end) begin
      move_second_q <= external_data_move && !move_second_q;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ale_q <= 1'b0;
      prs_q <= 1'b1;
    end else begin
      ale_q <= run_next && ale_slot && !ale_suppress;
      prs_q <= !(cpu_run && ext_fetch && !move_second_q && ph_q == PHASE_1 &&
                 (st_q == 3'h3 || st_q == 3'h0));
    end
  end

  // Strobe pins released to inputs while reset is active
  assign ale_out = ale_q;
  assign program_read_strobe_out = prs_q;
  assign ale_oe_n = in_reset;
  assign program_read_strobe_oe_n = in_reset;
  assign test_mode_hazard = in_reset && (ale_sync_q[1] || !prs_sync_q[1]);
endmodule

// [shared/reset_seq_pkg.sv]
/*
  Shared constants for the reset sequencer: machine-cycle timing, strobe
  phases, watchdog hold count and port reset values.
  Assumes one clock (clk, 25 MHz) standing for one oscillator period.
*/
package reset_seq_pkg;
  ////////////////////////////////////////////////////////////////////////
  // Machine-cycle timing
  localparam int unsigned OSC_PER_CYCLE = 12;
  localparam int unsigned STATES_PER_CYCLE = 6;
  localparam logic [2:0] STATE_LAST = 3'h5;
  localparam logic [2:0] STATE_S5 = 3'h4;
  localparam logic [2:0] STATE_S2 = 3'h1;
  localparam logic PHASE_1 = 1'b0;
  localparam logic PHASE_2 = 1'b1;
  localparam logic [1:0] RESET_CYCLES = 2'h2;
  // Watchdog hold
  localparam int unsigned WDOG_HOLD_RC_CYCLES = 768;
  localparam logic [9:0] WDOG_HOLD_LAST = 10'h2ff;
  // Reset values
  localparam logic [7:0] PORT_RESET = 8'hff;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam int unsigned PORT_COUNT = 4;
  // Timing figures
  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned EXT_RESET_US = 50;
  localparam int unsigned EXT_RESET_CYCLES = EXT_RESET_US * CLK_MHZ;
  // Sequencer states
  typedef enum logic [3:0] {
    ST_RESET = 4'h1,
    ST_INIT = 4'h2,
    ST_WAIT = 4'h4,
    ST_RUN = 4'h8
  } seq_state_t;
endpackage

// [src/osc_watchdog.sv]
/*
  Oscillator watchdog: compares main oscillator edges with RC ticks, picks
  the clock source and holds a reset request after the main oscillator
  recovers. Assumes the RC tick and main edge inputs are synchronised.
*/
module osc_watchdog
  import reset_seq_pkg::*;
#(
  parameter logic [9:0] HOLD_LAST = WDOG_HOLD_LAST
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic rc_tick,
  input wire logic main_edge,
  output logic use_rc_clock,
  output logic wdog_reset_req,
  output logic fail_event
);
  logic [1:0] rc_since_main_q;
  logic [1:0] rc_since_main_d;
  logic fail_q;
  logic [9:0] hold_q;
  logic hold_active_q;
  logic rc_faster;
  logic hold_done;

  //////////////////////////////////////////////////////////////////////////
  // Two RC ticks without a main edge means the RC clock runs faster
  assign rc_faster = rc_tick && (rc_since_main_q == 2'h1) && !main_edge;
  assign rc_since_main_d = main_edge ? 2'h0 : (rc_tick && rc_since_main_q != 2'h2 ?
                           rc_since_main_q + 2'h1 : rc_since_main_q);
  assign hold_done = hold_active_q && rc_tick && (hold_q == HOLD_LAST);
  assign use_rc_clock = fail_q || hold_active_q;
  assign wdog_reset_req = fail_q || hold_active_q;
  assign fail_event = rc_faster;

  // Failure detection; power-up starts in failure until main is seen
  always_ff @(posedge clk) begin
    if (srst) begin
      rc_since_main_q <= 2'h0;
      fail_q <= 1'b1;
    end else begin
      rc_since_main_q <= rc_since_main_d;
      if (rc_faster) begin
        fail_q <= 1'b1;
      end else if (main_edge && fail_q) begin
        fail_q <= 1'b0;
      end
    end
  end

  // Hold reset for the RC cycle count after recovery, then release
  always_ff @(posedge clk) begin
    if (srst) begin
      hold_q <= 10'h000;
      hold_active_q <= 1'b0;
    end else if (rc_faster) begin
      hold_q <= 10'h000;
      hold_active_q <= 1'b0;
    end else if (main_edge && fail_q) begin
      hold_q <= 10'h000;
      hold_active_q <= 1'b1;
    end else if (hold_done) begin
      hold_active_q <= 1'b0;
    end else if (hold_active_q && rc_tick) begin
      hold_q <= hold_q + 10'h001;
    end
  end
endmodule

// [verification/reset_seq_checker.sv]
/* Port checker for the reset sequencer, bound to its top module.
   Assumes one clock domain and synchronous active-high srst. */
module reset_seq_checker
  import reset_seq_pkg::*;
#(
  parameter logic [9:0] HOLD_LAST = WDOG_HOLD_LAST
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic reset_pin,
  input wire logic data_strobe_active,
  input wire logic ale_out,
  input wire logic ale_oe_n,
  input wire logic program_read_strobe_oe_n,
  input wire logic [7:0] port0_latch,
  input wire logic [7:0] port1_latch,
  input wire logic [7:0] port2_latch,
  input wire logic [7:0] port3_latch,
  input wire logic cpu_reset,
  input wire logic cpu_run,
  input wire logic sfr_default_load,
  input wire logic addr_out_start,
  input wire logic use_rc_clock,
  input wire logic osc_failure_flag,
  input wire logic power_down
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic [5:0] hi_q;
  logic [5:0] lo_q;
  ////////////////////////////////////////
  // Cycles the reset pin has stayed high or low, saturating
  always_ff @(posedge clk) begin
    hi_q <= (srst || !reset_pin) ? 6'h00 : hi_q + {5'h00, hi_q != 6'h3f};
    lo_q <= (srst || reset_pin) ? 6'h00 : lo_q + {5'h00, lo_q != 6'h3f};
  end
  property p_ports; sfr_default_load && $past(sfr_default_load) |-> (port0_latch & port1_latch & port2_latch & port3_latch) == 8'hff; endproperty
  a_ports: assert property (p_ports) else $error("port latches not all ones");
  property p_oe; cpu_reset |-> ale_oe_n && program_read_strobe_oe_n; endproperty
  a_oe: assert property (p_oe) else $error("strobe pins driven in reset");
  property p_start; addr_out_start |-> ale_out ##1 !ale_out; endproperty
  a_start: assert property (p_start) else $error("strobe edge wrong after start");
  property p_rate; $rose(ale_out) && cpu_run |-> ##6 (ale_out || data_strobe_active || power_down || cpu_reset); endproperty
  a_rate: assert property (p_rate) else $error("strobe not every six clocks");
  property p_proc; $rose(sfr_default_load) |-> sfr_default_load[*8] ##1 sfr_default_load[*8] ##1 sfr_default_load[*8]; endproperty
  a_proc: assert property (p_proc) else $error("procedure shorter than two cycles");
  property p_entry; hi_q == 6'h1a |-> ##[0:12] sfr_default_load; endproperty
  a_entry: assert property (p_entry) else $error("held reset not taken");
  property p_hold; hi_q >= 6'h20 |-> cpu_reset && !cpu_run; endproperty
  a_hold: assert property (p_hold) else $error("running while reset held");
  property p_pd; hi_q >= 6'h20 |-> !power_down; endproperty
  a_pd: assert property (p_pd) else $error("power-down survives reset");
  property p_flag; lo_q >= 6'h10 |-> !$fell(osc_failure_flag); endproperty
  a_flag: assert property (p_flag) else $error("failure flag cleared without reset");
  c_proc: cover property ($rose(sfr_default_load));
  c_run: cover property (addr_out_start);
  c_rc: cover property ($fell(use_rc_clock));
endmodule

bind reset_sequencer reset_seq_checker #(.HOLD_LAST(HOLD_LAST)) chk_u (
  .clk, .srst, .reset_pin, .data_strobe_active, .ale_out, .ale_oe_n, .program_read_strobe_oe_n,
  .port0_latch, .port1_latch, .port2_latch, .port3_latch, .cpu_reset, .cpu_run, .sfr_default_load,
  .addr_out_start, .use_rc_clock, .osc_failure_flag, .power_down
);

// [verification/reset_supervisor.sv]
/* Model of the external reset supervisor and both oscillator monitors.
   Assumes the bench calls hold_reset and raises main_on. */
module reset_supervisor (
  input wire logic clk,
  input wire logic main_on,
  output logic reset_pin,
  output logic rc_tick_pin,
  output logic main_edge_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] rc_q = 3'h0;
  initial reset_pin = 1'b1;
  initial main_edge_pin = 1'b0;
  // RC ticks every 8 clocks from power-on; main monitor toggles once started
  assign rc_tick_pin = rc_q[2];
  always @(posedge clk) begin
    rc_q <= rc_q + 3'h1;
    main_edge_pin <= main_on & !main_edge_pin;
  end
  // Holds reset n clocks, never less than one machine cycle
  task automatic hold_reset(input int n);
    @(posedge clk);
    #1 reset_pin = 1'b1;
    repeat (n < 12 ? 12 : n) @(posedge clk);
    #1 reset_pin = 1'b0;
  endtask
endmodule

// [verification/reset_sequencer_tb.sv]
/* Self-checking bench for the reset sequencer and the supervisor model.
   Assumes the package, design and checker are compiled first. */
module reset_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, srst = 1'b1, main_on = 1'b0, stim = 1'b0, ext_fetch = 1'b1;
  logic external_data_move = 1'b0, data_strobe_active = 1'b0, power_down_req = 1'b0;
  logic reset_pin, rc_tick_pin, main_edge_pin, ale_in, program_read_strobe_in, ale_out, ale_oe_n;
  logic program_read_strobe_out, program_read_strobe_oe_n, cpu_reset, cpu_run, sfr_default_load;
  logic addr_out_start, use_rc_clock, osc_failure_flag, power_down, test_mode_hazard;
  logic [7:0] port0_latch, port1_latch, port2_latch, port3_latch;
  logic [15:0] pc_start;
  int n_mismatch = 0, cmp_count = 0, pos = 0;
  // Released strobe pins idle inactive; stim acts as a misbehaving driver
  assign ale_in = ale_oe_n ? stim : ale_out;
  assign program_read_strobe_in = program_read_strobe_oe_n ? 1'b1 : program_read_strobe_out;
  // 25 MHz clock
  initial forever #20 clk = !clk;
  // Machine-cycle slot, aligned where run starts at S5P1
  always @(posedge clk) pos <= addr_out_start ? 9 : (pos + 1) % 12;
  reset_sequencer #(.HOLD_LAST(10'h007)) dut_u (
    .clk, .srst, .reset_pin, .rc_tick_pin, .main_edge_pin, .ext_fetch, .external_data_move,
    .data_strobe_active, .power_down_req, .ale_in, .program_read_strobe_in, .ale_out, .ale_oe_n,
    .program_read_strobe_out, .program_read_strobe_oe_n, .port0_latch, .port1_latch, .port2_latch,
    .port3_latch, .pc_start, .cpu_reset, .cpu_run, .sfr_default_load, .addr_out_start, .use_rc_clock,
    .osc_failure_flag, .power_down, .test_mode_hazard
  );
  reset_supervisor sup_u (.clk, .main_on, .reset_pin, .rc_tick_pin, .main_edge_pin);
  ////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic guard(input int i, input int lim);
    if (i >= lim) begin
      n_mismatch++;
      $display("[ERR] %0t wait ran out", $time);
      tally_and_finish();
    end
  endtask
  task automatic count_ale(input int n, output int na, output int np);
    logic pa, pp;
    na = 0;
    np = 0;
    pa = ale_out;
    pp = program_read_strobe_out;
    repeat (n) begin
      step(1);
      na += int'(ale_out && !pa);
      np += int'(!program_read_strobe_out && pp);
      pa = ale_out;
      pp = program_read_strobe_out;
    end
  endtask
  task automatic t_release(input int n);
    int i;
    sup_u.hold_reset(n);
    for (i = 0; i < 60 && addr_out_start !== 1'b1; i++) step(1);
    guard(i, 60);
    check(i >= 11 && i <= 28, 1);
    step(1);
    check({cpu_run, cpu_reset, ale_oe_n, pc_start}, 19'h40000);
  endtask
  task automatic t_power_on;
    int i, t;
    logic pr;
    t = 0;
    pr = rc_tick_pin;
    step(4);
    srst = 1'b0;
    check({use_rc_clock, osc_failure_flag, cpu_reset, ale_oe_n, program_read_strobe_oe_n}, 5'h1f);
    check({port0_latch, port1_latch, port2_latch, port3_latch}, 32'hffffffff);
    for (i = 0; i < 80 && sfr_default_load !== 1'b1; i++) step(1);
    guard(i, 80);
    check(i < 30, 1);
    step(60);
    check(use_rc_clock, 1);
    main_on = 1'b1;
    for (i = 0; i < 200 && use_rc_clock !== 1'b0; i++) begin
      step(1);
      t += int'(rc_tick_pin && !pr);
      pr = rc_tick_pin;
    end
    guard(i, 200);
    check(t >= 8 && t <= 10, 1);
    step(30);
    check({cpu_reset, cpu_run}, 2'b10);
    t_release(12);
    check(osc_failure_flag, 0);
  endtask
  task automatic t_ale_rate;
    int na, np;
    count_ale(48, na, np);
    check(na, 8);
    check(np, 8);
  endtask
  task automatic t_move;
    int i, na, np;
    for (i = 0; i < 12 && pos != 0; i++) step(1);
    external_data_move = 1'b1;
    step(12);
    external_data_move = 1'b0;
    data_strobe_active = 1'b1;
    count_ale(12, na, np);
    data_strobe_active = 1'b0;
    check(na, 1);
  endtask
  task automatic t_mid;
    int i;
    logic seen;
    seen = 1'b0;
    power_down_req = 1'b1;
    step(30);
    check(power_down, 1);
    power_down_req = 1'b0;
    fork
      t_release(40);
      begin
        for (i = 0; i < 30; i++) begin
          step(1);
          seen = seen | sfr_default_load;
        end
        stim = 1'b1;
        step(4);
        check({seen, cpu_reset, test_mode_hazard, power_down}, 4'he);
        stim = 1'b0;
      end
    join
    check(osc_failure_flag, 0);
  endtask
  // Main sequence
  initial begin
    t_power_on();
    t_ale_rate();
    t_move();
    t_mid();
    tally_and_finish();
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule
